/* File: design/slpr_params.svh */
// Constants of the solenoid limit and period register bank: frame field
// positions, register select codes, reset values and timing figures.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SLPR_PARAMS_SVH
`define SLPR_PARAMS_SVH

// ==========================================================
// Frame layout
`define SLPR_DATA_W 32
`define SLPR_ADDR_W 7
`define SLPR_RW_BIT 31
`define SLPR_SEL_HI 30
`define SLPR_SEL_LO 27
`define SLPR_CH_HI 25
`define SLPR_CH_LO 24
`define SLPR_HIGH_HI 23
`define SLPR_HIGH_LO 12
`define SLPR_LOW_HI 11
`define SLPR_LOW_LO 0
`define SLPR_EXP_HI 22
`define SLPR_EXP_LO 20
`define SLPR_PER_HI 11
`define SLPR_PER_LO 0

// ==========================================================
// Address port layout: frame bits 30:24 travel on the address port
`define SLPR_ADDR_SEL_HI 6
`define SLPR_ADDR_SEL_LO 3
`define SLPR_ADDR_CH_HI 1
`define SLPR_ADDR_CH_LO 0

// ==========================================================
// Register select codes and channel codes
`define SLPR_SEL_CLAMP 4'h4
`define SLPR_SEL_PERIOD 4'h5
`define SLPR_CH_FIRST 2'h1
`define SLPR_CH_SECOND 2'h2

// ==========================================================
// Reset values and limits
`define SLPR_CLAMP_RST 12'h7FF
`define SLPR_EXP_RST 3'h2
`define SLPR_EXP_MAX 3'h6
`define SLPR_EXP_SAT_IN 3'h7
`define SLPR_PER_RST 12'h000
`define SLPR_LIMIT_SHIFT 5
`define SLPR_PERIOD_SHIFT 4

// ==========================================================
// Timing
`define SLPR_SYS_CLK_NS 5
`define SLPR_PERIOD_TICKS_CLK 16
`define SLPR_PRESCALE_LAST 4'hF

`endif

/* File: design/slpr_pkg.sv */
// Types shared by the register bank and its channel slice.
// Assumes the constants header sits beside it.
`include "slpr_params.svh"

package slpr_pkg;

    // ==========================================================
    // Register select codes carried in frame bits 30:27
    typedef enum logic [3:0] {
        SLPR_SEL_CLAMP_REG = 4'b0100,
        SLPR_SEL_PERIOD_REG = 4'b0101
    } slpr_sel_type;

    // ==========================================================
    // Channel codes carried in frame bits 25:24
    typedef enum logic [1:0] {
        SLPR_CH_NONE = 2'b00,
        SLPR_CH_FIRST_LOAD = 2'b01,
        SLPR_CH_SECOND_LOAD = 2'b10,
        SLPR_CH_BOTH = 2'b11
    } slpr_chan_type;

    typedef logic [11:0] slpr_field_type;
    typedef logic [2:0] slpr_exp_type;

endpackage

/* File: design/slpr_channel.sv */
// One load channel: clamp, exponent and period fields and the
// period start tick. Assumes the parent decodes frames into write strobes.
`timescale 1ns/1ps
`include "slpr_params.svh"

module slpr_channel
    import slpr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_clamp,
    input wire logic wr_period,
    input wire logic [31:0] wdata,
    output slpr_field_type high_field,
    output slpr_field_type low_field,
    output slpr_exp_type gain_exp,
    output slpr_field_type period_field,
    output logic period_start
);

    // ==========================================================
    // Stored fields
    slpr_field_type high_r, high_nxt;
    slpr_field_type low_r, low_nxt;
    slpr_exp_type exp_r, exp_nxt;
    slpr_field_type per_r, per_nxt;
    slpr_exp_type exp_in;

    // Field update, unused frame bits simply never looked at
    always_comb begin
        exp_in = wdata[`SLPR_EXP_HI:`SLPR_EXP_LO];
        high_nxt = high_r;
        low_nxt = low_r;
        exp_nxt = exp_r;
        per_nxt = per_r;
        if (wr_clamp) begin
            high_nxt = wdata[`SLPR_HIGH_HI:`SLPR_HIGH_LO];
            low_nxt = wdata[`SLPR_LOW_HI:`SLPR_LOW_LO];
        end
        if (wr_period) begin
            // Seven is not a legal gain, so it is stored as six
            exp_nxt = (exp_in == `SLPR_EXP_SAT_IN) ? `SLPR_EXP_MAX : exp_in;
            per_nxt = wdata[`SLPR_PER_HI:`SLPR_PER_LO];
        end
    end

    // Field registers
    always_ff @(posedge clk) begin
        if (rst) begin
            high_r <= `SLPR_CLAMP_RST;
            low_r <= `SLPR_CLAMP_RST;
            exp_r <= `SLPR_EXP_RST;
            per_r <= `SLPR_PER_RST;
        end else begin
            high_r <= high_nxt;
            low_r <= low_nxt;
            exp_r <= exp_nxt;
            per_r <= per_nxt;
        end
    end

    // ==========================================================
    // Period tick: one count of the field is sixteen clocks
    logic [3:0] pre_r, pre_nxt;
    slpr_field_type cnt_r, cnt_nxt;
    logic start_r, start_nxt;

    // A period write restarts the cycle so the new length takes hold cleanly
    always_comb begin
        pre_nxt = pre_r + 4'h1;
        cnt_nxt = cnt_r;
        start_nxt = 1'b0;
        if (wr_period || per_r == 12'h000) begin
            pre_nxt = 4'h0;
            cnt_nxt = 12'h000;
        end else if (pre_r == `SLPR_PRESCALE_LAST) begin
            if (cnt_r == per_r - 12'h001) begin
                cnt_nxt = 12'h000;
                start_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 12'h001;
            end
        end
    end

    // Tick registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_r <= 4'h0;
            cnt_r <= 12'h000;
            start_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            start_r <= start_nxt;
        end
    end

    assign high_field = high_r;
    assign low_field = low_r;
    assign gain_exp = exp_r;
    assign period_field = per_r;
    assign period_start = start_r;

endmodule

/* File: design/slpr_regs.sv */
// Register bank for the integrator clamp and modulation period settings
// of a two-channel solenoid current controller.
// Assumes a synchronous master on a plain strobe port and one 200 MHz clock.
//
// Overview of operation
// - Frame bit 31 set means write and clear means read, and read data carry 0 there.
// - Channel code 01 picks the first load channel and 10 the second one.
// - The upper clamp field in bits 23:12 gives a positive limit of 32 times its value.
// - Each channel's upper clamp field resets to 07FF hex.
// - The lower clamp field in bits 11:0 gives a negative limit of -32 times its value.
// - Each channel's lower clamp field resets to 07FF hex.
// - The exponent in bits 22:20 sets the integral gain to two to its negative.
// - A written exponent of 7 is stored and used as 6.
// - Each channel's exponent resets to 010 binary, a gain of one quarter.
// - The period field in bits 11:0 counts units of sixteen system clocks.
`timescale 1ns/1ps
`include "slpr_params.svh"

module slpr_regs
    import slpr_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic bus_err,
    output logic [CHANNELS-1:0][16:0] upper_limit,
    output logic [CHANNELS-1:0][17:0] lower_limit,
    output logic [CHANNELS-1:0][2:0] integral_gain_exponent,
    output logic [CHANNELS-1:0][6:0] integral_gain,
    output logic [CHANNELS-1:0][15:0] period_clocks,
    output logic [CHANNELS-1:0] period_start
);

    // ==========================================================
    // Address decode
    slpr_sel_type sel;
    logic [1:0] chan;
    logic sel_clamp;
    logic sel_period;
    logic chan_ok;
    logic [CHANNELS-1:0] chan_hit;

    // Bit 2 of the address is the unused frame bit 26
    always_comb begin
        sel = slpr_sel_type'(bus_addr[`SLPR_ADDR_SEL_HI:`SLPR_ADDR_SEL_LO]);
        chan = bus_addr[`SLPR_ADDR_CH_HI:`SLPR_ADDR_CH_LO];
        sel_clamp = (sel == SLPR_SEL_CLAMP_REG);
        sel_period = (sel == SLPR_SEL_PERIOD_REG);
        chan_hit = '0;
        chan_hit[0] = (chan == `SLPR_CH_FIRST);
        chan_hit[1] = (chan == `SLPR_CH_SECOND);
        chan_ok = |chan_hit;
    end

    // ==========================================================
    // Write strobes per channel
    logic wr_take;
    logic [CHANNELS-1:0] wr_clamp;
    logic [CHANNELS-1:0] wr_period;

    // A frame with the access bit clear is a read request, never a write
    always_comb begin
        wr_take = bus_wr && bus_wdata[`SLPR_RW_BIT];
        wr_clamp = (wr_take && sel_clamp) ? chan_hit : '0;
        wr_period = (wr_take && sel_period) ? chan_hit : '0;
    end

    // ==========================================================
    // Channel slices
    slpr_field_type high_f [CHANNELS];
    slpr_field_type low_f [CHANNELS];
    slpr_exp_type exp_f [CHANNELS];
    slpr_field_type per_f [CHANNELS];
    logic [CHANNELS-1:0] start_f;

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            slpr_channel u_chan (
                .clk(clk),
                .rst(rst),
                .wr_clamp(wr_clamp[gi]),
                .wr_period(wr_period[gi]),
                .wdata(bus_wdata),
                .high_field(high_f[gi]),
                .low_field(low_f[gi]),
                .gain_exp(exp_f[gi]),
                .period_field(per_f[gi]),
                .period_start(start_f[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Read back
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic ch_idx;

    // Data stand only in the cycle after the strobe; otherwise zero
    always_comb begin
        ch_idx = chan_hit[1];
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (bus_rd) begin
            if (chan_ok && sel_clamp) begin
                rdata_nxt[`SLPR_SEL_HI:`SLPR_SEL_LO] = `SLPR_SEL_CLAMP;
                rdata_nxt[`SLPR_CH_HI:`SLPR_CH_LO] = chan;
                rdata_nxt[`SLPR_HIGH_HI:`SLPR_HIGH_LO] = high_f[ch_idx];
                rdata_nxt[`SLPR_LOW_HI:`SLPR_LOW_LO] = low_f[ch_idx];
            end else if (chan_ok && sel_period) begin
                rdata_nxt[`SLPR_SEL_HI:`SLPR_SEL_LO] = `SLPR_SEL_PERIOD;
                rdata_nxt[`SLPR_CH_HI:`SLPR_CH_LO] = chan;
                rdata_nxt[`SLPR_EXP_HI:`SLPR_EXP_LO] = exp_f[ch_idx];
                rdata_nxt[`SLPR_PER_HI:`SLPR_PER_LO] = per_f[ch_idx];
            end else begin
                err_nxt = 1'b1;
            end
            rdata_nxt[`SLPR_RW_BIT] = 1'b0;
        end else if (bus_wr && !(chan_ok && (sel_clamp || sel_period))) begin
            // Unmapped writes are dropped, flagged for one cycle
            err_nxt = 1'b1;
        end
    end

    // Read data and error registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    // ==========================================================
    // Effective values for the regulation datapath
    logic [CHANNELS-1:0][16:0] up_r, up_nxt;
    logic [CHANNELS-1:0][17:0] lo_r, lo_nxt;
    logic [CHANNELS-1:0][2:0] ex_r, ex_nxt;
    logic [CHANNELS-1:0][6:0] ki_r, ki_nxt;
    logic [CHANNELS-1:0][15:0] pc_r, pc_nxt;
    logic [CHANNELS-1:0] ps_r, ps_nxt;

    // Registered once more so every output leaves from a flip-flop
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            up_nxt[i] = {high_f[i], 5'h00};
            lo_nxt[i] = 18'h00000 - {1'b0, low_f[i], 5'h00};
            ex_nxt[i] = exp_f[i];
            // Gain as a fraction of 64: 2^-e scaled, e never above six
            ki_nxt[i] = 7'h40 >> exp_f[i];
            pc_nxt[i] = {per_f[i], 4'h0};
            ps_nxt[i] = start_f[i];
        end
    end

    // Effective value registers
    always_ff @(posedge clk) begin
        if (rst) begin
            up_r <= '0;
            lo_r <= '0;
            ex_r <= '0;
            ki_r <= '0;
            pc_r <= '0;
            ps_r <= '0;
        end else begin
            up_r <= up_nxt;
            lo_r <= lo_nxt;
            ex_r <= ex_nxt;
            ki_r <= ki_nxt;
            pc_r <= pc_nxt;
            ps_r <= ps_nxt;
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_err = err_r;
    assign upper_limit = up_r;
    assign lower_limit = lo_r;
    assign integral_gain_exponent = ex_r;
    assign integral_gain = ki_r;
    assign period_clocks = pc_r;
    assign period_start = ps_r;

endmodule

/* File: dv/slpr_regs_assertions.sv */
// Port checker of the clamp and period register bank.
// Assumes binding to slpr_regs through the statement at the foot.
`timescale 1ns/1ps
module slpr_regs_assertions #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [6:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_err,
    input wire logic [CHANNELS-1:0][16:0] upper_limit,
    input wire logic [CHANNELS-1:0][17:0] lower_limit,
    input wire logic [CHANNELS-1:0][2:0] integral_gain_exponent,
    input wire logic [CHANNELS-1:0][6:0] integral_gain,
    input wire logic [CHANNELS-1:0][15:0] period_clocks,
    input wire logic [CHANNELS-1:0] period_start
);
    // ====
    // Properties; effective outputs follow a write by two edges
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic wr_go = bus_wr && bus_wdata[31];
    // Frame bit 26 rides on address bit 2 and is ignored, so it is masked here
    wire logic clamp_w0 = wr_go && bus_addr[6:3] == 4'h4 && bus_addr[1:0] == 2'h1;
    wire logic period_w1 = wr_go && bus_addr[6:3] == 4'h5 && bus_addr[1:0] == 2'h2;

    AST_RD_BIT31: assert property (bus_rdata[31] == 1'b0)
        else $error("read data carry the access bit");
    AST_RD_IDLE: assert property (!bus_rd |=> bus_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    AST_UPPER: assert property (clamp_w0 |-> ##2
        upper_limit[0] == {$past(bus_wdata[23:12], 2), 5'h00})
        else $error("upper limit not 32 times field");
    AST_LOWER: assert property (clamp_w0 |-> ##2
        lower_limit[0] == 18'h0 - {1'b0, $past(bus_wdata[11:0], 2), 5'h00})
        else $error("lower limit not minus 32 times field");
    AST_EXP_SAT: assert property (period_w1 |-> ##2
        integral_gain_exponent[1] == (($past(bus_wdata[22:20], 2) == 3'h7) ?
        3'h6 : $past(bus_wdata[22:20], 2)))
        else $error("exponent not stored or saturated");
    AST_PERIOD: assert property (period_w1 |-> ##2
        period_clocks[1] == {$past(bus_wdata[11:0], 2), 4'h0})
        else $error("period not 16 clocks per count");
    AST_GAIN: assert property (!$past(rst) |->
        integral_gain[0] == (7'h40 >> integral_gain_exponent[0]))
        else $error("gain does not follow exponent");
    AST_ERR: assert property (bus_rd && (!(bus_addr[6:3] inside {4'h4, 4'h5}) ||
        bus_addr[1:0] inside {2'h0, 2'h3}) |=> bus_err && bus_rdata == 32'h0)
        else $error("unmapped read not flagged");
    AST_TICK: assert property ($rose(period_start[0]) |=>
        (!period_start[0]) [*8] ##1 (!period_start[0]) [*7])
        else $error("period ticks closer than 16 clocks");
    AST_WR_ERR: assert property (bus_wr && (!(bus_addr[6:3] inside {4'h4, 4'h5}) ||
        bus_addr[1:0] inside {2'h0, 2'h3}) |=> bus_err)
        else $error("unmapped write not flagged");

    cover property (period_w1 && bus_wdata[22:20] == 3'h7);
    cover property (bus_rd ##1 bus_err);
    cover property (period_start[0] ##16 period_start[0]);
endmodule

bind slpr_regs slpr_regs_assertions #(.CHANNELS(CHANNELS)) chk_u (.clk(clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .bus_err(bus_err), .upper_limit(upper_limit),
    .lower_limit(lower_limit), .integral_gain_exponent(integral_gain_exponent),
    .integral_gain(integral_gain), .period_clocks(period_clocks),
    .period_start(period_start));

/* File: dv/slpr_host_model.sv */
// Host model issuing 32-bit register frames on the strobe port.
// Assumes calls only after reset has been released.
`timescale 1ns/1ps
module slpr_host_model (
    input wire logic clk,
    output logic [6:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_err
);
    // ====
    // Bus tasks; released lines flip so stale values are never trusted
    initial begin
        bus_addr = 7'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    task automatic put(input logic [31:0] frame);
        @(posedge clk);
        bus_addr <= frame[30:24];
        bus_wdata <= frame;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_addr <= ~frame[30:24];
        bus_wdata <= ~frame;
    endtask

    task automatic get(input logic [31:0] frame, output logic [31:0] d, output logic e);
        @(posedge clk);
        bus_addr <= frame[30:24];
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        bus_addr <= ~frame[30:24];
        @(posedge clk);
        d = bus_rdata;
        e = bus_err;
    endtask
endmodule

/* File: dv/slpr_regs_tb_top.sv */
// Self-checking bench of the clamp and period register bank.
// Assumes the host model drives the bus and an integer model predicts.
`timescale 1ns/1ps
module slpr_regs_tb_top;
    // ====
    // Signals and reference model
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [31:0] bus_rdata;
    logic bus_wr;
    logic bus_rd;
    logic bus_err;
    logic [1:0][16:0] upper_limit;
    logic [1:0][17:0] lower_limit;
    logic [1:0][2:0] integral_gain_exponent;
    logic [1:0][6:0] integral_gain;
    logic [1:0][15:0] period_clocks;
    logic [1:0] period_start;
    int n_fail = 0;
    int checks = 0;
    int seed = 32'hc35d;
    int cycles = 0;
    int hi[2] = '{12'h7FF, 12'h7FF};
    int lo[2] = '{12'h7FF, 12'h7FF};
    int ex[2] = '{2, 2};
    int per[2] = '{0, 0};

    slpr_regs dut_u (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_err(bus_err),
        .upper_limit(upper_limit), .lower_limit(lower_limit),
        .integral_gain_exponent(integral_gain_exponent), .integral_gain(integral_gain),
        .period_clocks(period_clocks), .period_start(period_start));
    slpr_host_model host_u (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_err(bus_err));

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] clamp_f(input int c);
        return 32'h20000000 | ((c + 1) << 24) | (hi[c] << 12) | lo[c];
    endfunction
    function automatic logic [31:0] per_f(input int c);
        return 32'h28000000 | ((c + 1) << 24) | (ex[c] << 20) | per[c];
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic rd_cmp(input logic [31:0] f, input logic [31:0] want, input logic werr);
        logic [31:0] d;
        logic e;
        host_u.get(f, d, e);
        cmp(d, want);
        cmp({31'h0, e}, {31'h0, werr});
    endtask
    // Derived outputs against the integer model
    task automatic out_cmp(input int c);
        cmp({15'h0, upper_limit[c]}, hi[c] * 32);
        cmp({14'h0, lower_limit[c]}, (-(lo[c] * 32)) & 32'h3FFFF);
        cmp({29'h0, integral_gain_exponent[c]}, ex[c]);
        cmp({25'h0, integral_gain[c]}, 64 >> ex[c]);
        cmp({16'h0, period_clocks[c]}, per[c] * 16);
    endtask
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ====
    // Scenarios
    initial begin
        int c;
        int t;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (c = 0; c < 2; c++) begin
            rd_cmp(clamp_f(c), clamp_f(c), 1'b0);
            rd_cmp(per_f(c), per_f(c), 1'b0);
            out_cmp(c);
        end
        $display("test reset_values done");
        // Every exponent including the saturating one, then random clamps
        for (int i = 0; i < 14; i++) begin
            c = i % 2;
            if (i < 8) begin
                per[c] = $random(seed) & 32'hFFF;
                host_u.put(32'hA8000000 | ((c + 1) << 24) | (i << 20) | per[c] |
                    ($random(seed) & 32'h048FF000));
                ex[c] = (i == 7) ? 6 : i;
                rd_cmp(per_f(c), per_f(c), 1'b0);
            end else begin
                hi[c] = (i == 8) ? 32'hFFF : $random(seed) & 32'hFFF;
                lo[c] = (i == 9) ? 0 : $random(seed) & 32'hFFF;
                host_u.put(clamp_f(c) | 32'h84000000);
                rd_cmp(clamp_f(c), clamp_f(c), 1'b0);
            end
            out_cmp(c);
        end
        $display("test write_readback done");
        // Refused frames leave every setting untouched
        host_u.put(clamp_f(0) ^ 32'h00FFF000);
        host_u.put(32'hB10FF123);
        host_u.put(32'hA30FF123);
        rd_cmp(clamp_f(0), clamp_f(0), 1'b0);
        rd_cmp(32'h31000000, 32'h0, 1'b1);
        rd_cmp(32'h20000000, 32'h0, 1'b1);
        rd_cmp(32'h2B000000, 32'h0, 1'b1);
        out_cmp(0);
        out_cmp(1);
        $display("test refused done");
        // Shortest period: one count gives a tick every 16 clocks
        per[0] = 1;
        host_u.put(32'hA9000000 | (ex[0] << 20) | 1);
        t = 0;
        while (period_start[0] !== 1'b1 && t < 100) begin
            @(posedge clk);
            t++;
        end
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (period_start[0] !== 1'b1 && t < 100);
        cmp(t, 16);
        $display("test period_tick done");
        print_verdict();
    end
endmodule
